// ==== shared/fpe_pkg.sv ====
package fpe_pkg;

   // ------------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------------
   localparam logic [7:0] A_CODE_WAIT = 8'h00;
   localparam logic [7:0] A_DATA_WAIT = 8'h04;
   localparam logic [7:0] A_MODE = 8'h08;
   localparam logic [7:0] A_INIT = 8'h0C;
   localparam logic [7:0] A_XCMD = 8'h10;
   localparam logic [7:0] A_PROT = 8'h14;
   localparam logic [7:0] A_WSTART = 8'h18;
   localparam logic [7:0] A_WEND = 8'h1C;
   localparam logic [7:0] A_CMD = 8'h20;
   localparam logic [7:0] A_ADDR = 8'h24;
   localparam logic [7:0] A_WDATA = 8'h28;
   localparam logic [7:0] A_STAT = 8'h2C;
   localparam logic [7:0] A_IRQ_ST = 8'h30;
   localparam logic [7:0] A_IRQ_MSK = 8'h34;
   localparam logic [7:0] A_UID = 8'h38;
   localparam logic [7:0] A_IDCHK = 8'h3C;

   // ------------------------------------------------------------------
   // Field codes and bit positions
   // ------------------------------------------------------------------
   localparam logic [1:0] MODE_READ = 2'h0;
   localparam logic [1:0] MODE_CODE_PE = 2'h1;
   localparam logic [1:0] MODE_DATA_PE = 2'h2;
   localparam logic [1:0] MODE_BAD = 2'h3;
   localparam logic [2:0] XCMD_STARTUP = 3'h1;
   localparam logic [2:0] XCMD_WINDOW = 3'h2;
   localparam logic [2:0] CMD_PROG = 3'h1;
   localparam logic [2:0] CMD_BLANK = 3'h2;
   localparam logic [2:0] CMD_BLK_ERASE = 3'h3;
   localparam logic [2:0] CMD_ALL_ERASE = 3'h4;
   localparam logic [2:0] CMD_EXTRA = 3'h5;
   localparam int CMD_STOP_BIT = 7;
   localparam int PROT_SEL_BIT = 8;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_STOP = 1;
   localparam int IRQ_ERR = 2;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_ERR_BIT = 1;
   localparam int ST_BLANK_BIT = 2;
   localparam int ST_SWAP_BIT = 3;
   localparam int ST_ID_BIT = 4;

   // ------------------------------------------------------------------
   // Reset values and memory geometry
   // ------------------------------------------------------------------
   localparam logic [7:0] RST_WAIT = 8'h00;
   localparam logic [15:0] RST_WIN_START = 16'h0000;
   localparam logic [15:0] RST_WIN_END = 16'h0080;
   localparam logic [2:0] RST_IRQ_MSK = 3'h0;
   localparam logic [5:0] RST_PCLK = 6'h00;
   localparam logic [31:0] CODE_BASE_256K = 32'hFFFC_0000;
   localparam logic [31:0] CODE_BASE_128K = 32'hFFFE_0000;
   localparam logic [31:0] CODE_BASE_64K = 32'hFFFF_0000;
   localparam logic [31:0] DATA_BASE = 32'h0010_0000;
   localparam logic [31:0] DATA_MAX_BYTES = 32'h0000_2000;
   localparam int BLK_LSB = 11;
   localparam logic [6:0] STARTUP_LAST_BLK = 7'h07;
   localparam logic [6:0] STARTUP_SWAP_MASK = 7'h08;
   localparam logic [31:0] ERASED_WORD = 32'hFFFF_FFFF;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_BUSY = 2'b10
   } fpe_state_t;

endpackage : fpe_pkg

// ==== rtl/fpe_flash_seq.sv ====
// Register access over AHB-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ps
module fpe_flash_seq #(
   parameter int CAPACITY_SEL = 0,
   parameter logic [31:0] UNIQUE_ID = 32'h5A5A_0001,
   parameter logic [31:0] ACCESS_ID = 32'hC3C3_0002
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic boot_mode,
   output logic fm_req,
   output logic [2:0] fm_op,
   output logic fm_area,
   output logic [17:0] fm_addr,
   output logic [31:0] fm_wdata,
   output logic [5:0] fm_pclk,
   input wire logic fm_done,
   input wire logic [31:0] fm_rdata,
   output logic [7:0] code_wait,
   output logic [7:0] data_wait,
   output logic cf_read_ok,
   output logic df_read_ok,
   output logic serial_channel_one_en,
   output logic debug_conn_en,
   output logic flash_done_irq
);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      logic ready;
      logic wr_pend;
      logic [7:0] wa;
      logic [31:0] rdata;
      logic [7:0] code_wait;
      logic [7:0] data_wait;
      logic [1:0] mode;
      logic [5:0] pclk;
      logic [2:0] xcmd;
      logic [31:0] tgt_addr;
      logic [31:0] wdata;
      logic [15:0] win_start;
      logic [15:0] win_end;
      logic win_lock;
      logic swap;
      logic [2:0] irq_st;
      logic [2:0] irq_msk;
      logic irq;
      logic err;
      logic blank;
      logic id_ok;
      logic cf_ok;
      logic df_ok;
      logic ser_en;
      fpe_pkg::fpe_state_t state;
      logic fm_req;
      logic [2:0] fm_op;
      logic fm_area;
      logic [17:0] fm_addr;
   } fpe_regs_t;

   localparam logic [31:0] CODE_BASE = (CAPACITY_SEL == 0) ? fpe_pkg::CODE_BASE_256K :
                                       (CAPACITY_SEL == 1) ? fpe_pkg::CODE_BASE_128K :
                                       fpe_pkg::CODE_BASE_64K;

   fpe_regs_t s;
   fpe_regs_t n;

   localparam int BLK_LSB_HI = 17;

   // Block number of a code flash offset against the configured window.
   function automatic logic in_window(input logic [31:0] off, input logic [15:0] ws, input logic [15:0] we);
      logic [15:0] blk;
      blk = {9'h000, off[BLK_LSB_HI:fpe_pkg::BLK_LSB]};
      return (blk >= ws) && (blk < we);
   endfunction : in_window

   function automatic logic [31:0] read_mux(input logic [7:0] a, input fpe_regs_t r);
      logic [31:0] d;
      d = 32'h0000_0000;
      case (a)
         fpe_pkg::A_CODE_WAIT: d[7:0] = r.code_wait;
         fpe_pkg::A_DATA_WAIT: d[7:0] = r.data_wait;
         fpe_pkg::A_MODE: d[1:0] = r.mode;
         fpe_pkg::A_INIT: d[5:0] = r.pclk;
         fpe_pkg::A_XCMD: d[2:0] = r.xcmd;
         fpe_pkg::A_PROT: d[0] = r.win_lock;
         fpe_pkg::A_WSTART: d[15:0] = r.win_start;
         fpe_pkg::A_WEND: d[15:0] = r.win_end;
         fpe_pkg::A_ADDR: d = r.tgt_addr;
         fpe_pkg::A_WDATA: d = r.wdata;
         fpe_pkg::A_STAT: begin
            d[fpe_pkg::ST_BUSY_BIT] = (r.state == fpe_pkg::ST_BUSY);
            d[fpe_pkg::ST_ERR_BIT] = r.err;
            d[fpe_pkg::ST_BLANK_BIT] = r.blank;
            d[fpe_pkg::ST_SWAP_BIT] = r.swap;
            d[fpe_pkg::ST_ID_BIT] = r.id_ok;
         end
         fpe_pkg::A_IRQ_ST: d[2:0] = r.irq_st;
         fpe_pkg::A_IRQ_MSK: d[2:0] = r.irq_msk;
         fpe_pkg::A_UID: d = UNIQUE_ID;
         default: d = 32'h0000_0000;
      endcase
      return d;
   endfunction : read_mux

   // ------------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------------
   logic start;
   logic stop;
   logic [2:0] cmd;
   logic [2:0] clr;
   logic [2:0] ev;
   logic is_code;
   logic is_data;
   logic [31:0] code_off;
   logic [31:0] data_off;
   logic [6:0] blk;

   always_comb begin
      n = s;
      start = 1'b0;
      stop = 1'b0;
      cmd = 3'h0;
      clr = 3'h0;
      ev = 3'h0;
      n.wr_pend = 1'b0;
      n.ready = 1'b1;
      code_off = s.tgt_addr - CODE_BASE;
      data_off = s.tgt_addr - fpe_pkg::DATA_BASE;
      blk = code_off[BLK_LSB_HI:fpe_pkg::BLK_LSB];
      is_code = (s.tgt_addr >= CODE_BASE);
      is_data = (s.tgt_addr >= fpe_pkg::DATA_BASE) && (data_off < fpe_pkg::DATA_MAX_BYTES);
      // Zero-wait slave: read data is fetched in the address phase so it leaves a flop.
      // A read whose address phase meets the data phase of a write returns the old value,
      // because the mux looks at the registers before that write lands.
      if (hready && hsel && htrans[1]) begin
         if (hwrite) begin
            n.wr_pend = 1'b1;
            n.wa = haddr[7:0];
         end else begin
            n.rdata = read_mux(haddr[7:0], s);
         end
      end
      if (s.wr_pend) begin
         case (s.wa)
            fpe_pkg::A_CODE_WAIT: n.code_wait = hwdata[7:0];
            fpe_pkg::A_DATA_WAIT: n.data_wait = hwdata[7:0];
            fpe_pkg::A_MODE: begin
               // The prohibited code is dropped so the mode never leaves the legal set.
               if (hwdata[1:0] != fpe_pkg::MODE_BAD) begin
                  n.mode = hwdata[1:0];
               end
            end
            fpe_pkg::A_INIT: n.pclk = hwdata[5:0];
            fpe_pkg::A_XCMD: n.xcmd = hwdata[2:0];
            fpe_pkg::A_CMD: begin
               stop = hwdata[fpe_pkg::CMD_STOP_BIT];
               start = !hwdata[fpe_pkg::CMD_STOP_BIT] && (s.state == fpe_pkg::ST_IDLE);
               cmd = hwdata[2:0];
            end
            fpe_pkg::A_ADDR: begin
               if (s.state == fpe_pkg::ST_IDLE) begin
                  n.tgt_addr = hwdata;
               end
            end
            fpe_pkg::A_WDATA: begin
               if (s.state == fpe_pkg::ST_IDLE) begin
                  n.wdata = hwdata;
               end
            end
            fpe_pkg::A_IRQ_ST: clr = hwdata[2:0];
            fpe_pkg::A_IRQ_MSK: n.irq_msk = hwdata[2:0];
            fpe_pkg::A_IDCHK: n.id_ok = (hwdata == ACCESS_ID);
            default: n.ready = 1'b1;
         endcase
      end

      unique case (s.state)
         fpe_pkg::ST_IDLE: begin
            if (stop) begin
               ev[fpe_pkg::IRQ_STOP] = 1'b1;
            end else if (start) begin
               n.err = 1'b0;
               n.blank = 1'b0;
               n.fm_op = cmd;
               if (cmd == fpe_pkg::CMD_EXTRA) begin
                  if (s.xcmd == fpe_pkg::XCMD_STARTUP) begin
                     if (s.wdata[fpe_pkg::PROT_SEL_BIT]) begin
                        n.win_lock = 1'b1;
                     end else begin
                        n.swap = s.wdata[0];
                     end
                     ev[fpe_pkg::IRQ_DONE] = 1'b1;
                  end else if (s.xcmd == fpe_pkg::XCMD_WINDOW && !s.win_lock) begin
                     n.win_start = s.wdata[15:0];
                     n.win_end = s.wdata[31:16];
                     ev[fpe_pkg::IRQ_DONE] = 1'b1;
                  end else begin
                     n.err = 1'b1;
                     ev[fpe_pkg::IRQ_ERR] = 1'b1;
                  end
               end else if (cmd == fpe_pkg::CMD_ALL_ERASE &&
                            (s.mode == fpe_pkg::MODE_CODE_PE || s.mode == fpe_pkg::MODE_DATA_PE)) begin
                  n.fm_area = (s.mode == fpe_pkg::MODE_DATA_PE);
                  n.fm_addr = 18'h00000;
                  n.fm_req = 1'b1;
                  n.state = fpe_pkg::ST_BUSY;
               end else if ((cmd == fpe_pkg::CMD_PROG || cmd == fpe_pkg::CMD_BLANK ||
                             cmd == fpe_pkg::CMD_BLK_ERASE) && is_code &&
                            s.mode == fpe_pkg::MODE_CODE_PE &&
                            (cmd == fpe_pkg::CMD_BLANK || in_window(code_off, s.win_start, s.win_end))) begin
                  n.fm_area = 1'b0;
                  n.fm_addr = code_off[17:0];
                  // Start-up blocks are redirected to their alternates while swap is armed.
                  if (s.swap && blk <= fpe_pkg::STARTUP_LAST_BLK) begin
                     n.fm_addr[BLK_LSB_HI:fpe_pkg::BLK_LSB] = blk ^ fpe_pkg::STARTUP_SWAP_MASK;
                  end
                  n.fm_req = 1'b1;
                  n.state = fpe_pkg::ST_BUSY;
               end else if ((cmd == fpe_pkg::CMD_PROG || cmd == fpe_pkg::CMD_BLANK ||
                             cmd == fpe_pkg::CMD_BLK_ERASE) && is_data &&
                            s.mode == fpe_pkg::MODE_DATA_PE) begin
                  n.fm_area = 1'b1;
                  n.fm_addr = data_off[17:0];
                  n.fm_req = 1'b1;
                  n.state = fpe_pkg::ST_BUSY;
               end else begin
                  n.err = 1'b1;
                  ev[fpe_pkg::IRQ_ERR] = 1'b1;
               end
            end
         end
         fpe_pkg::ST_BUSY: begin
            if (stop) begin
               n.fm_req = 1'b0;
               n.state = fpe_pkg::ST_IDLE;
               ev[fpe_pkg::IRQ_STOP] = 1'b1;
            end else if (fm_done) begin
               n.fm_req = 1'b0;
               n.state = fpe_pkg::ST_IDLE;
               ev[fpe_pkg::IRQ_DONE] = 1'b1;
               if (s.fm_op == fpe_pkg::CMD_BLANK) begin
                  n.blank = (fm_rdata == fpe_pkg::ERASED_WORD);
               end
            end
         end
         default: begin
            n.fm_req = 1'b0;
            n.state = fpe_pkg::ST_IDLE;
         end
      endcase

      // Set wins over a simultaneous write-one clear.
      n.irq_st = (s.irq_st & ~clr) | ev;
      n.irq = |(n.irq_st & n.irq_msk);
      n.cf_ok = (n.mode != fpe_pkg::MODE_CODE_PE);
      n.df_ok = (n.mode != fpe_pkg::MODE_DATA_PE);
      n.ser_en = boot_mode && n.id_ok;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
         s.ready <= 1'b1;
         s.code_wait <= fpe_pkg::RST_WAIT;
         s.data_wait <= fpe_pkg::RST_WAIT;
         s.mode <= fpe_pkg::MODE_READ;
         s.pclk <= fpe_pkg::RST_PCLK;
         s.win_start <= fpe_pkg::RST_WIN_START;
         s.win_end <= fpe_pkg::RST_WIN_END;
         s.irq_msk <= fpe_pkg::RST_IRQ_MSK;
         s.cf_ok <= 1'b1;
         s.df_ok <= 1'b1;
         s.state <= fpe_pkg::ST_IDLE;
      end else begin
         s <= n;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign hreadyout = s.ready;
   assign hresp = 1'b0;
   assign hrdata = s.rdata;
   assign fm_req = s.fm_req;
   assign fm_op = s.fm_op;
   assign fm_area = s.fm_area;
   assign fm_addr = s.fm_addr;
   assign fm_wdata = s.wdata;
   assign fm_pclk = s.pclk;
   assign code_wait = s.code_wait;
   assign data_wait = s.data_wait;
   assign cf_read_ok = s.cf_ok;
   assign df_read_ok = s.df_ok;
   assign serial_channel_one_en = s.ser_en;
   assign debug_conn_en = s.id_ok;
   assign flash_done_irq = s.irq;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   mode_legal_a: assert property (@(posedge hclk) disable iff (!hresetn) s.mode != fpe_pkg::MODE_BAD)
      else $error("mode field holds the prohibited code");

   done_irq_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (s.state == fpe_pkg::ST_BUSY && fm_done && !stop) |=> s.irq_st[fpe_pkg::IRQ_DONE] && !s.fm_req)
      else $error("finished command did not flag done");

   stop_irq_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (stop && s.state == fpe_pkg::ST_BUSY) |=> s.state == fpe_pkg::ST_IDLE && s.irq_st[fpe_pkg::IRQ_STOP])
      else $error("forced stop did not finish with its flag");

   mode_reject_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (start && cmd == fpe_pkg::CMD_PROG && s.mode == fpe_pkg::MODE_READ) |=> s.err && !s.fm_req)
      else $error("program accepted in read mode");

   window_only_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ($rose(s.fm_req) && !s.fm_area && s.fm_op == fpe_pkg::CMD_PROG && !s.swap) |->
      in_window({14'h0000, s.fm_addr}, s.win_start, s.win_end))
      else $error("program issued outside the window");

   lock_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
      s.win_lock |=> s.win_lock && $stable(s.win_start) && $stable(s.win_end))
      else $error("locked window changed");

   bgo_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (s.mode == fpe_pkg::MODE_DATA_PE) |-> cf_read_ok)
      else $error("code reads blocked during data flash work");

   blank_check_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (s.state == fpe_pkg::ST_BUSY && fm_done && !stop && s.fm_op == fpe_pkg::CMD_BLANK) |=>
      s.blank == ($past(fm_rdata) == fpe_pkg::ERASED_WORD))
      else $error("blank result does not match erased pattern");

   irq_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
      flash_done_irq == |(s.irq_st & s.irq_msk))
      else $error("interrupt line disagrees with status and mask");

endmodule : fpe_flash_seq

// ==== tb/fpe_flash_model.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Flash array model
// ------------------------------------------------------------------
module fpe_flash_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic fm_req,
   input wire logic [2:0] fm_op,
   input wire logic [17:0] fm_addr,
   input wire logic [31:0] fm_wdata,
   input wire logic [7:0] dly,
   output logic fm_done,
   output logic [31:0] fm_rdata
);
   logic [31:0] mem [16];
   logic [7:0] cnt;
   logic fired;
   assign fm_rdata = mem[fm_addr[5:2]];
   // The array starts programmed, so a blank check before any erase must fail.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt <= 8'h00;
         fired <= 1'b0;
         fm_done <= 1'b0;
         for (int i = 0; i < 16; i++) mem[i] <= 32'h0000_0000;
      end else if (!fm_req) begin
         cnt <= 8'h00;
         fired <= 1'b0;
         fm_done <= 1'b0;
      end else if (fired) begin
         fm_done <= 1'b0;
      end else if (cnt == dly) begin
         fm_done <= 1'b1;
         fired <= 1'b1;
         if (fm_op == fpe_pkg::CMD_PROG) mem[fm_addr[5:2]] <= mem[fm_addr[5:2]] & fm_wdata;
         // Erase wipes the whole small array; block granularity is not modelled.
         if (fm_op == fpe_pkg::CMD_BLK_ERASE || fm_op == fpe_pkg::CMD_ALL_ERASE) begin
            for (int i = 0; i < 16; i++) mem[i] <= fpe_pkg::ERASED_WORD;
         end
      end else begin
         cnt <= cnt + 8'h01;
      end
   end
endmodule : fpe_flash_model

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
   localparam logic [31:0] TB_UID = 32'h1357_2468; // Arbitrary value.
   localparam logic [31:0] TB_AID = 32'h2468_9ACE; // Arbitrary value.
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, boot_mode, fm_done, fm_req, fm_area;
   logic cf_read_ok, df_read_ok, serial_channel_one_en, debug_conn_en, flash_done_irq;
   logic [31:0] haddr, hwdata, hrdata, fm_wdata, fm_rdata, rv, cb;
   logic [1:0] htrans;
   logic [2:0] hsize, fm_op;
   logic [17:0] fm_addr;
   logic [5:0] fm_pclk;
   logic [7:0] code_wait, data_wait, dly;
   int failures, checked, n;
   logic [2:0] ops [5] = '{3'h1, 3'h2, 3'h4, 3'h2, 3'h3};
   logic bexp [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
   assign hready = hreadyout;
   fpe_flash_seq #(.CAPACITY_SEL(0), .UNIQUE_ID(TB_UID), .ACCESS_ID(TB_AID)) u_fpe_flash_seq (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .boot_mode(boot_mode), .fm_req(fm_req), .fm_op(fm_op), .fm_area(fm_area),
      .fm_addr(fm_addr), .fm_wdata(fm_wdata), .fm_pclk(fm_pclk), .fm_done(fm_done), .fm_rdata(fm_rdata),
      .code_wait(code_wait), .data_wait(data_wait), .cf_read_ok(cf_read_ok), .df_read_ok(df_read_ok),
      .serial_channel_one_en(serial_channel_one_en), .debug_conn_en(debug_conn_en),
      .flash_done_irq(flash_done_irq));
   fpe_flash_model u_fpe_flash_model (.hclk(hclk), .hresetn(hresetn), .fm_req(fm_req), .fm_op(fm_op),
      .fm_addr(fm_addr), .fm_wdata(fm_wdata), .dly(dly), .fm_done(fm_done), .fm_rdata(fm_rdata));
   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   task print_verdict;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // ------------------------------------------------------------------
   // AHB-Lite single word transfers
   // ------------------------------------------------------------------
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      rv = hrdata;
      #1;
   endtask : bus
   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task rc(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      check(rv, e);
   endtask : rc
   task rb(input logic [7:0] a, input int b, input logic e);
      bus(1'b0, a, 32'h0000_0000);
      check({31'h0, rv[b]}, {31'h0, e});
   endtask : rb
   task cmd(input logic [2:0] op, input logic [31:0] a, input logic [31:0] d);
      wr(fpe_pkg::A_ADDR, a);
      wr(fpe_pkg::A_WDATA, d);
      wr(fpe_pkg::A_CMD, {29'h0, op});
   endtask : cmd
   task idle;
      n = 0;
      do begin
         bus(1'b0, fpe_pkg::A_STAT, 32'h0000_0000);
         n++;
      end while (rv[fpe_pkg::ST_BUSY_BIT] !== 1'b0 && n < 100);
   endtask : idle
   task xc(input logic [2:0] x, input logic [31:0] d);
      wr(fpe_pkg::A_XCMD, {29'h0, x});
      cmd(fpe_pkg::CMD_EXTRA, 32'h0000_0000, d);
      idle();
   endtask : xc
   initial begin
      repeat (20000) @(posedge hclk);
      failures++;
      print_verdict();
   end
   initial begin
      hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2;
      hwdata = '0; boot_mode = 1'b0; dly = 8'h03; failures = 0; checked = 0;
      cb = fpe_pkg::CODE_BASE_256K;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      rc(fpe_pkg::A_CODE_WAIT, {24'h0, fpe_pkg::RST_WAIT});
      rc(fpe_pkg::A_WSTART, {16'h0, fpe_pkg::RST_WIN_START});
      rc(fpe_pkg::A_WEND, {16'h0, fpe_pkg::RST_WIN_END});
      rc(fpe_pkg::A_PROT, 32'h0000_0000);
      rc(fpe_pkg::A_UID, TB_UID);
      check({30'h0, cf_read_ok, df_read_ok}, 32'h0000_0003);
      check({31'h0, hresp}, 32'h0000_0000);
      wr(fpe_pkg::A_CODE_WAIT, 32'h0000_00A5);
      wr(fpe_pkg::A_DATA_WAIT, 32'h0000_005A);
      wr(fpe_pkg::A_INIT, 32'h0000_002A);
      rc(fpe_pkg::A_DATA_WAIT, 32'h0000_005A);
      check({16'h0, code_wait, data_wait}, 32'h0000_A55A);
      check({26'h0, fm_pclk}, 32'h0000_002A);
      wr(8'h40, 32'hFFFF_FFFF);
      rc(8'h40, 32'h0000_0000);
      cmd(fpe_pkg::CMD_PROG, cb, 32'h0000_0000);
      idle();
      rb(fpe_pkg::A_STAT, fpe_pkg::ST_ERR_BIT, 1'b1);
      wr(fpe_pkg::A_MODE, {30'h0, fpe_pkg::MODE_CODE_PE});
      check({31'h0, cf_read_ok}, 32'h0000_0000);
      cmd(fpe_pkg::CMD_PROG, fpe_pkg::DATA_BASE, 32'h0000_0000);
      check({31'h0, fm_req}, 32'h0000_0000);
      idle();
      rb(fpe_pkg::A_STAT, fpe_pkg::ST_ERR_BIT, 1'b1);
      wr(fpe_pkg::A_IRQ_MSK, 32'h0000_0007);
      @(posedge hclk);
      #1 check({31'h0, flash_done_irq}, 32'h0000_0001);
      wr(fpe_pkg::A_IRQ_ST, 32'h0000_0007);
      @(posedge hclk);
      #1 check({31'h0, flash_done_irq}, 32'h0000_0000);
      wr(fpe_pkg::A_MODE, {30'h0, fpe_pkg::MODE_DATA_PE});
      wr(fpe_pkg::A_MODE, {30'h0, fpe_pkg::MODE_BAD});
      rc(fpe_pkg::A_MODE, {30'h0, fpe_pkg::MODE_DATA_PE});
      check({30'h0, cf_read_ok, df_read_ok}, 32'h0000_0002);
      wr(fpe_pkg::A_IRQ_MSK, 32'h0000_0003);
      for (int i = 0; i < 5; i++) begin
         cmd(ops[i], fpe_pkg::DATA_BASE, 32'h1234_5678);
         check({27'h0, fm_req, fm_area, fm_op}, {27'h0, 2'h3, ops[i]});
         check(fm_wdata, 32'h1234_5678);
         idle();
         rb(fpe_pkg::A_IRQ_ST, fpe_pkg::IRQ_DONE, 1'b1);
         if (ops[i] == fpe_pkg::CMD_BLANK) rb(fpe_pkg::A_STAT, fpe_pkg::ST_BLANK_BIT, bexp[i]);
         wr(fpe_pkg::A_IRQ_ST, 32'h0000_0007);
      end
      cmd(fpe_pkg::CMD_PROG, fpe_pkg::DATA_BASE + fpe_pkg::DATA_MAX_BYTES, 32'h0000_0000);
      idle();
      rb(fpe_pkg::A_STAT, fpe_pkg::ST_ERR_BIT, 1'b1);
      dly = 8'h28;
      cmd(fpe_pkg::CMD_BLK_ERASE, fpe_pkg::DATA_BASE, 32'h0000_0000);
      repeat (10) @(posedge hclk);
      #1 check({30'h0, fm_req, cf_read_ok}, 32'h0000_0003);
      wr(fpe_pkg::A_CMD, 32'h0000_0080);
      check({31'h0, fm_req}, 32'h0000_0000);
      rb(fpe_pkg::A_IRQ_ST, fpe_pkg::IRQ_STOP, 1'b1);
      check({31'h0, flash_done_irq}, 32'h0000_0001);
      wr(fpe_pkg::A_IRQ_ST, 32'h0000_0007);
      dly = 8'h03;
      wr(fpe_pkg::A_MODE, {30'h0, fpe_pkg::MODE_CODE_PE});
      xc(fpe_pkg::XCMD_WINDOW, 32'h0010_0004);
      rc(fpe_pkg::A_WSTART, 32'h0000_0004);
      rc(fpe_pkg::A_WEND, 32'h0000_0010);
      for (int b = 2; b < 18; b += 2) begin
         cmd(fpe_pkg::CMD_PROG, cb + (b << 11), 32'h0000_0000);
         idle();
         rb(fpe_pkg::A_STAT, fpe_pkg::ST_ERR_BIT, b < 4 || b > 15);
      end
      cmd(fpe_pkg::CMD_PROG, cb - 32'h4, 32'h0000_0000);
      idle();
      rb(fpe_pkg::A_STAT, fpe_pkg::ST_ERR_BIT, 1'b1);
      xc(fpe_pkg::XCMD_WINDOW, 32'h0080_0000);
      xc(fpe_pkg::XCMD_STARTUP, 32'h0000_0001);
      rb(fpe_pkg::A_STAT, fpe_pkg::ST_SWAP_BIT, 1'b1);
      cmd(fpe_pkg::CMD_PROG, cb, 32'h0000_0000);
      check({25'h0, fm_addr[17:11]}, {25'h0, fpe_pkg::STARTUP_SWAP_MASK});
      idle();
      xc(3'h3, 32'h0000_0000);
      rb(fpe_pkg::A_STAT, fpe_pkg::ST_ERR_BIT, 1'b1);
      xc(fpe_pkg::XCMD_STARTUP, 32'h0000_0100);
      rc(fpe_pkg::A_PROT, 32'h0000_0001);
      xc(fpe_pkg::XCMD_WINDOW, 32'h0010_0004);
      rb(fpe_pkg::A_STAT, fpe_pkg::ST_ERR_BIT, 1'b1);
      rc(fpe_pkg::A_WSTART, 32'h0000_0000);
      wr(fpe_pkg::A_IDCHK, TB_AID);
      @(posedge hclk);
      boot_mode <= 1'b1;
      repeat (2) @(posedge hclk);
      #1 check({30'h0, serial_channel_one_en, debug_conn_en}, 32'h0000_0003);
      rb(fpe_pkg::A_STAT, fpe_pkg::ST_ID_BIT, 1'b1);
      wr(fpe_pkg::A_IDCHK, TB_AID ^ 32'h0000_0001);
      repeat (2) @(posedge hclk);
      #1 check({30'h0, serial_channel_one_en, debug_conn_en}, 32'h0000_0000);
      print_verdict();
   end
endmodule : testbench
